// ---- tb.sv ----
// Self-checking bench for the trigger input register bank.
// Assumes trgin_regs with shortened scaler gate and second span, and trgin_fe_model.
`timescale 1ns/1ps
module tb;
  import trgin_pkg::*;
  logic            clock_i = 1'b0;
  logic            sys_rst_i = 1'b1;
  logic [8:0]      avs_address_i = '0;
  logic            avs_read_i = 1'b0;
  logic            avs_write_i = 1'b0;
  logic [31:0]     avs_writedata_i = '0;
  logic [31:0]     avs_readdata_o;
  logic            avs_waitrequest_o;
  logic [NHIT-1:0] hit, shaped;
  logic            acc, pps;
  logic [7:0]      cal, pps_tap, acc_tap, code;
  logic            load;
  logic [2:0]      tclu, tpix, offs;
  int              loads = 0;
  int              bad_count = 0, check_count = 0, m[128], n, cnt, ix;
  logic [31:0]     seed = 32'h0000_9391, q, v;
  logic [6:0]      rw[5] = '{7'h07, 7'h08, 7'h09, 7'h0c, 7'h40};
  int              wt[4] = '{0, 1, 3, 7};
  int              md[4] = '{0, 1, 2, 4};
  logic [7:0]      tg[2] = '{8'h00, 8'h30};
  always #2 clock_i = ~clock_i;
  always @(posedge clock_i)
    if (load === 1'b1) loads <= loads + 1;
  trgin_fe_model u_fe (.clock_i(clock_i), .hit_o(hit), .accept_o(acc), .pulse_o(pps), .cal_o(cal));
  trgin_regs #(.SCALER_CYCLES(2000), .PPS_TICKS(20)) u_trgin_regs (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h1),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .pixel_hit_signal_i(hit),
    .accept_trigger_i(acc), .second_pulse_i(pps), .second_pulse_cal_i(cal), .shaped_hit_o(shaped),
    .second_pulse_tap_o(pps_tap), .accept_tap_o(acc_tap), .pixel_tap_load_o(load), .pixel_tap_cluster_o(tclu),
    .pixel_tap_pixel_o(tpix), .pixel_tap_code_o(code), .pixel_tap_offset_o(offs));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Writable bits of each index but control (index 0 gives zero); everything else reads zero
  function automatic int wm(input int i);
    if (i >= 16 && i <= 22) return PIXEL_EXISTS[(i-16)*8 +: 8];
    case (i)
      6, 11: return 7;
      7, 8, 10: return 255;
      9: return 8'h77;
      default: return 0;
    endcase
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic w, input logic [6:0] i, input logic [7:0] d);
    @(posedge clock_i);
    avs_address_i <= {i, 2'b00};
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h00_0000, d};
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
    m[i] = d & wm(i);
  endtask
  task automatic rd(input logic [6:0] i);
    bus(1'b0, i, 8'h00);
    chk(q, m[i]);
  endtask
  task automatic stat(input int b, input logic e);
    bus(1'b0, 7'h01, 8'h00);
    chk(q[b], e);
  endtask
  task automatic shape(input int idx);
    cnt = 0;
    fork
      u_fe.hits(idx, 1);
      repeat (14) @(negedge clock_i) cnt += int'(shaped[idx] === 1'b1);
    join
  endtask
  initial begin
    foreach (m[i]) m[i] = (i >= 16 && i <= 22) ? wm(i) : (i == 6) ? 2 : 0;
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (int i = 6; i < 24; i++) rd(i[6:0]);
    $display("test reset done");
    repeat (3) begin
      foreach (rw[k]) begin
        v = xs();
        wr(rw[k], v[7:0]);
      end
      foreach (rw[k]) rd(rw[k]);
      chk(pps_tap, m[7]);
      chk(acc_tap, m[8]);
    end
    for (int i = 16; i < 23; i++) begin
      wr(i[6:0], 8'hff);
      rd(i[6:0]);
    end
    v = xs();
    u_fe.set_cal(v[7:0]);
    m[15] = v[7:0];
    repeat (3) @(posedge clock_i);
    rd(7'h0f);
    $display("test registers done");
    foreach (wt[k]) begin
      wr(7'h06, wt[k] | 8'hf8);
      rd(7'h06);
      shape(0);
      chk(cnt, wt[k] == 0 ? 2 : wt[k]);
    end
    wr(7'h10, 8'h7e);
    foreach (md[k]) begin
      wr(7'h00, md[k]);
      shape(0);
      chk(cnt, 0);
    end
    wr(7'h10, 8'h7f);
    $display("test shaping done");
    foreach (tg[k]) begin
      ix = tg[k][6:4] * NPIX + tg[k][2:0];
      wr(7'h09, tg[k]);
      wr(7'h0b, 8'hfd);
      rd(7'h0b);
      chk(offs, m[11]);
      chk({tclu, tpix}, {tg[k][6:4], tg[k][2:0]});
      wr(7'h0a, 8'he0);
      stat(2, 1'b0);
      chk(code, m[10]);
      v = xs();
      n = v % 3 + 1;
      wr(7'h0a, {v[10:8], n[4:0]});
      u_fe.hits(ix, 1);
      wr(7'h0a, {v[10:8], n[4:0]});
      @(negedge clock_i) chk(code, m[10]);
      u_fe.hits(ix, 2 * n - 1);
      stat(2, 1'b1);
      u_fe.hits(ix, 1);
      repeat (4) @(posedge clock_i);
      stat(2, 1'b0);
    end
    wr(7'h09, 8'h65);
    wr(7'h0a, 8'h05);
    stat(2, 1'b0);
    chk(loads, 8);
    $display("test pixel delay done");
    u_fe.seconds(100, 3);
    u_fe.seconds(95, 1);
    u_fe.seconds(100, 1);
    m[14] = 1;
    rd(7'h0e);
    stat(4, 1'b1);
    u_fe.seconds(95, 260);
    m[14] = 255;
    rd(7'h0e);
    wr(7'h00, 8'h20);
    wr(7'h00, 8'h00);
    m[14] = 0;
    rd(7'h0e);
    $display("test second pulse done");
    fork
      u_fe.accepts(1700);
      begin
        repeat (5000) @(posedge clock_i);
        m[12] = 8'hf4;
        m[13] = 8'h01;
        rd(7'h0c);
        rd(7'h0d);
      end
    join
    $display("test rate done");
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge clock_i);
    bad_count++;
    stop_test();
  end
endmodule

// ---- trgin_fe_model.sv ----
// Far-side model: front-end pixel hits, accept trigger, second pulse and calibration value.
// Assumes the bench calls its tasks; every output changes just after a rising clock edge.
`timescale 1ns/1ps
module trgin_fe_model
  import trgin_pkg::*;
(
  // Clock
  input  wire logic            clock_i,
  // Far-side signals
  output logic      [NHIT-1:0] hit_o,
  output logic                 accept_o,
  output logic                 pulse_o,
  output logic      [7:0]      cal_o
);
  initial begin
    hit_o = '0;
    accept_o = 1'b0;
    pulse_o = 1'b0;
    cal_o = 8'h00;
  end
  // Two cycles over threshold, two below, so every pulse has a clean leading edge
  task automatic hits(input int idx, input int n);
    repeat (n) begin
      @(posedge clock_i) hit_o[idx] <= 1'b1;
      repeat (2) @(posedge clock_i);
      hit_o[idx] <= 1'b0;
      @(posedge clock_i);
    end
  endtask
  // Accept edges every four cycles
  task automatic accepts(input int n);
    repeat (n) begin
      @(posedge clock_i) accept_o <= 1'b1;
      repeat (2) @(posedge clock_i);
      accept_o <= 1'b0;
      @(posedge clock_i);
    end
  endtask
  // Gap counts from the previous call's last edge, so one call can shorten one interval
  task automatic seconds(input int gap, input int n);
    repeat (n) begin
      repeat (gap - 1) @(posedge clock_i);
      pulse_o <= 1'b1;
      @(posedge clock_i) pulse_o <= 1'b0;
    end
  endtask
  task automatic set_cal(input logic [7:0] c);
    @(posedge clock_i) cal_o <= c;
  endtask
endmodule

// ---- trgin_pkg.sv ----
// Package for the trigger input timing register bank.
// Assumes one 250 MHz clock and a 32-bit Avalon-MM register port.
package trgin_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [6:0] IDX_CONTROL     = 7'h00;
  localparam logic [6:0] IDX_STATUS      = 7'h01;
  localparam logic [6:0] IDX_COINC_WIN   = 7'h06;
  localparam logic [6:0] IDX_SECOND_PULSE_INPUT_DELAY     = 7'h07;
  localparam logic [6:0] IDX_ACC_DEL     = 7'h08;
  localparam logic [6:0] IDX_TARGET_SEL  = 7'h09;
  localparam logic [6:0] IDX_PIX_DEL     = 7'h0a;
  localparam logic [6:0] IDX_PIX_OFFS    = 7'h0b;
  localparam logic [6:0] IDX_RATE_LOW    = 7'h0c;
  localparam logic [6:0] IDX_RATE_HIGH   = 7'h0d;
  localparam logic [6:0] IDX_MISMATCH    = 7'h0e;
  localparam logic [6:0] IDX_CAL_DEL     = 7'h0f;
  localparam logic [6:0] IDX_MASK_FIRST  = 7'h10;
  localparam logic [6:0] IDX_MASK_LAST   = 7'h16;
  // Field positions
  localparam int CTRL_CLR_MISMATCH_BIT  = 5;
  localparam int STAT_PIX_BUSY_BIT      = 2;
  localparam int STAT_PPS_ERROR_BIT     = 4;
  localparam int COINC_WIN_W            = 3;
  localparam int FINE_W                 = 5;
  localparam int COARSE_LSB             = 5;
  localparam int OFFS_W                 = 3;
  localparam logic [7:0] TARGET_SEL_MASK = 8'h77;
  // Reset values
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [7:0] COINC_WIN_RESET = 8'h02;
  localparam logic [7:0] DELAY_RESET     = 8'h00;
  // Pixels per cluster and clusters, and which positions exist
  localparam int NPIX      = 7;
  localparam int NCLU      = 7;
  localparam int NHIT      = NPIX * NCLU;
  localparam logic [NCLU*8-1:0] PIXEL_EXISTS = {8'h1f, 8'h4f, 8'h6b, 8'h79, 8'h7c, 8'h3e, 8'h7f};
  // Timing
  localparam longint CLK_FREQ_HZ       = 250_000_000;
  localparam longint SYS_TICK_HZ       = 50_000_000;
  localparam int     SYS_TICK_DIV      = int'(CLK_FREQ_HZ / SYS_TICK_HZ);
  localparam longint SCALER_WINDOW_MS  = 1000;
  localparam longint SCALER_WINDOW_CYC = CLK_FREQ_HZ / 1000 * SCALER_WINDOW_MS;
  localparam longint PPS_TICKS_PER_SEC = SYS_TICK_HZ;
  localparam int     FINE_PULSES_PER_STEP = 2;
endpackage

// ---- trgin_regs.sv ----
// Register bank for trigger input conditioning: hit masking and shaping,
// delay tap codes, trigger rate scaler and second-pulse supervision.
// Assumes all inputs synchronous to clock_i; delay lines are external and take tap codes.
`timescale 1ns/1ps

// Contract
// - Window zero passes hits unshaped; nonzero x stretches hits for a 2x-1 ns window; code holds x clock cycles (4x ns).
// - Shaping acts on hit leading edges before the trigger fabric.
// - Second-pulse input delay register sets its delay in 37 ps steps, max 87h.
// - Accept input delay register sets accept delay in 37 ps steps, max 87h.
// - Target select holds pixel in bits 2..0, cluster in 6..4; bits 3,7 zero.
// - Pixel delay bits 4..0 give fine delay in 37 ps steps for the target.
// - Pixel delay bits 7..5 give coarse 1 ns steps, active at once, no busy.
// - Fine value 1..31 needs 2..62 target hits; busy stays set until done.
// - Delay handling is identical for every cluster, no central offset.
// - Pixel delay offset register gives a per-pixel 3-bit coarse offset.
// - Rate scaler shows trigger frequency in Hz as low and high read-only bytes.
// - Mismatch counter counts second intervals not equal to 50 million ticks.
// - Mismatch counter saturates at FFh.
// - Read-only register reports the calibrated second-pulse delay.
// - Mask bit zero forces that pixel's hit input low.
// - Mask readback shows ones only at maskable pixel positions.
// - Masking applies in every trigger mode.
// - Control bit 5 at one clears the mismatch counter.
// - Pixel delay write while busy restarts adjustment with newest value.
// - Busy stays inactive for nonexistent pixel positions.
module trgin_regs
  import trgin_pkg::*;
#(
  parameter longint SCALER_CYCLES = SCALER_WINDOW_CYC,
  parameter longint PPS_TICKS     = PPS_TICKS_PER_SEC
) (
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               sys_rst_i,
  // Avalon-MM slave
  input  wire logic [8:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // Front-end and timing inputs
  input  wire logic [NHIT-1:0]    pixel_hit_signal_i,
  input  wire logic               accept_trigger_i,
  input  wire logic               second_pulse_i,
  input  wire logic [7:0]         second_pulse_cal_i,
  // To trigger fabric and delay lines
  output logic      [NHIT-1:0]    shaped_hit_o,
  output logic      [7:0]         second_pulse_tap_o,
  output logic      [7:0]         accept_tap_o,
  output logic                    pixel_tap_load_o,
  output logic      [2:0]         pixel_tap_cluster_o,
  output logic      [2:0]         pixel_tap_pixel_o,
  output logic      [7:0]         pixel_tap_code_o,
  output logic      [OFFS_W-1:0]  pixel_tap_offset_o
);

  function automatic logic pix_exists(input logic [2:0] clu, input logic [2:0] pix);
    pix_exists = (clu < 3'(NCLU)) && (pix < 3'(NPIX)) && PIXEL_EXISTS[clu*8+pix];
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hff) ? v : v + 8'h01;
  endfunction

  logic [7:0]        control_reg;
  logic [7:0]        coinc_window_reg;
  logic [7:0]        pps_delay_reg;
  logic [7:0]        acc_delay_reg;
  logic [7:0]        target_sel_reg;
  logic [7:0]        pix_delay_reg;
  logic [OFFS_W-1:0] pix_offs_mem [NHIT];
  logic [7:0]        mask_reg [NCLU];
  logic [15:0]       rate_reg;
  logic [7:0]        mismatch_reg;
  logic [7:0]        cal_delay_reg;
  logic              pix_busy_reg;
  logic [6:0]        pulses_left_reg;
  logic [31:0]       rdata_next;
  logic              ack;
  logic              wr_en;
  logic [6:0]        idx;
  logic [2:0]        sel_clu;
  logic [2:0]        sel_pix;
  logic [5:0]        sel_flat;
  logic              sel_ok;

  assign idx      = avs_address_i[8:2];
  assign ack      = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  assign wr_en    = ack && avs_write_i && avs_byteenable_i[0];
  assign sel_clu  = target_sel_reg[6:4];
  assign sel_pix  = target_sel_reg[2:0];
  assign sel_flat = 6'(sel_clu * NPIX + sel_pix);
  assign sel_ok   = pix_exists(sel_clu, sel_pix);

  // Bus handshake: one wait cycle, then one answer cycle; write lands on the answer edge
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (idx)
      IDX_CONTROL:    rdata_next[7:0] = control_reg;
      IDX_STATUS: begin
        rdata_next[STAT_PIX_BUSY_BIT]  = pix_busy_reg;
        rdata_next[STAT_PPS_ERROR_BIT] = (mismatch_reg != 8'h00);
      end
      IDX_COINC_WIN:  rdata_next[7:0] = coinc_window_reg;
      IDX_SECOND_PULSE_INPUT_DELAY:    rdata_next[7:0] = pps_delay_reg;
      IDX_ACC_DEL:    rdata_next[7:0] = acc_delay_reg;
      IDX_TARGET_SEL: rdata_next[7:0] = target_sel_reg;
      IDX_PIX_DEL:    rdata_next[7:0] = pix_delay_reg;
      IDX_PIX_OFFS:   rdata_next[OFFS_W-1:0] = sel_ok ? pix_offs_mem[sel_flat] : '0;
      IDX_RATE_LOW:   rdata_next[7:0] = rate_reg[7:0];
      IDX_RATE_HIGH:  rdata_next[7:0] = rate_reg[15:8];
      IDX_MISMATCH:   rdata_next[7:0] = mismatch_reg;
      IDX_CAL_DEL:    rdata_next[7:0] = cal_delay_reg;
      default: begin
        if (idx >= IDX_MASK_FIRST && idx <= IDX_MASK_LAST) begin
          rdata_next[7:0] = mask_reg[3'(idx - IDX_MASK_FIRST)];
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rdata_next;
    end
  end

  // Plain read/write registers; reserved bits never stored
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      control_reg      <= CONTROL_RESET;
      coinc_window_reg <= COINC_WIN_RESET;
      pps_delay_reg    <= DELAY_RESET;
      acc_delay_reg    <= DELAY_RESET;
      target_sel_reg   <= DELAY_RESET;
      pix_delay_reg    <= DELAY_RESET;
    end else if (wr_en) begin
      unique case (idx)
        IDX_CONTROL:    control_reg      <= avs_writedata_i[7:0];
        IDX_COINC_WIN:  coinc_window_reg <= {5'h00, avs_writedata_i[COINC_WIN_W-1:0]};
        IDX_SECOND_PULSE_INPUT_DELAY:    pps_delay_reg    <= avs_writedata_i[7:0];
        IDX_ACC_DEL:    acc_delay_reg    <= avs_writedata_i[7:0];
        IDX_TARGET_SEL: target_sel_reg   <= avs_writedata_i[7:0] & TARGET_SEL_MASK;
        IDX_PIX_DEL:    pix_delay_reg    <= avs_writedata_i[7:0];
        default: ;
      endcase
    end
  end

  // Mask registers keep only bits of pixels that exist
  always_ff @(posedge clock_i) begin
    for (int c = 0; c < NCLU; c++) begin
      if (sys_rst_i) begin
        mask_reg[c] <= PIXEL_EXISTS[c*8 +: 8];
      end else if (wr_en && idx == IDX_MASK_FIRST + 7'(c)) begin
        mask_reg[c] <= avs_writedata_i[7:0] & PIXEL_EXISTS[c*8 +: 8];
      end
    end
  end

  // Offsets only matter once after power-up; held per pixel so each can be re-read
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < NHIT; i++) begin
      if (sys_rst_i) begin
        pix_offs_mem[i] <= '0;
      end else if (wr_en && idx == IDX_PIX_OFFS && sel_ok && sel_flat == 6'(i)) begin
        pix_offs_mem[i] <= avs_writedata_i[OFFS_W-1:0];
      end
    end
  end

  // Tap codes to the delay lines
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      second_pulse_tap_o  <= DELAY_RESET;
      accept_tap_o        <= DELAY_RESET;
      pixel_tap_load_o    <= 1'b0;
      pixel_tap_cluster_o <= 3'h0;
      pixel_tap_pixel_o   <= 3'h0;
      pixel_tap_code_o    <= DELAY_RESET;
      pixel_tap_offset_o  <= '0;
    end else begin
      second_pulse_tap_o <= pps_delay_reg;
      accept_tap_o       <= acc_delay_reg;
      // Same load path for every cluster, no extra offset anywhere
      pixel_tap_load_o   <= wr_en && (idx == IDX_PIX_DEL || idx == IDX_PIX_OFFS) && sel_ok;
      if (wr_en && sel_ok && idx == IDX_PIX_DEL) begin
        pixel_tap_cluster_o <= sel_clu;
        pixel_tap_pixel_o   <= sel_pix;
        pixel_tap_code_o    <= avs_writedata_i[7:0];
        pixel_tap_offset_o  <= pix_offs_mem[sel_flat];
      end else if (wr_en && sel_ok && idx == IDX_PIX_OFFS) begin
        pixel_tap_cluster_o <= sel_clu;
        pixel_tap_pixel_o   <= sel_pix;
        pixel_tap_code_o    <= pix_delay_reg;
        pixel_tap_offset_o  <= avs_writedata_i[OFFS_W-1:0];
      end
    end
  end

  // Hit masking right at the input, ahead of any trigger mode
  logic [NHIT-1:0] mask_flat;
  logic [NHIT-1:0] masked_hit_reg;
  logic [NHIT-1:0] masked_prev_reg;
  logic [2:0]      stretch_cnt [NHIT];
  logic [2:0]      win_len;

  assign win_len = coinc_window_reg[COINC_WIN_W-1:0];

  always_comb begin
    for (int i = 0; i < NHIT; i++) begin
      mask_flat[i] = mask_reg[i / NPIX][i % NPIX];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      masked_hit_reg  <= '0;
      masked_prev_reg <= '0;
    end else begin
      masked_hit_reg  <= pixel_hit_signal_i & mask_flat;
      masked_prev_reg <= masked_hit_reg;
    end
  end

  // With a nonzero window a leading edge restarts a fixed-length pulse; the hit's own length is discarded
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < NHIT; i++) begin
      if (sys_rst_i) begin
        stretch_cnt[i]  <= 3'h0;
        shaped_hit_o[i] <= 1'b0;
      end else if (win_len == 3'h0) begin
        stretch_cnt[i]  <= 3'h0;
        shaped_hit_o[i] <= masked_hit_reg[i];
      end else if (masked_hit_reg[i] && !masked_prev_reg[i]) begin
        stretch_cnt[i]  <= win_len - 3'h1;
        shaped_hit_o[i] <= 1'b1;
      end else if (stretch_cnt[i] != 3'h0) begin
        stretch_cnt[i]  <= stretch_cnt[i] - 3'h1;
        shaped_hit_o[i] <= 1'b1;
      end else begin
        shaped_hit_o[i] <= 1'b0;
      end
    end
  end

  // Fine delay settling counts leading edges on the target pixel
  logic sel_edge;
  assign sel_edge = masked_hit_reg[sel_flat] && !masked_prev_reg[sel_flat];

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pix_busy_reg    <= 1'b0;
      pulses_left_reg <= 7'h00;
    end else if (wr_en && idx == IDX_PIX_DEL) begin
      // Newest write restarts the count; coarse-only writes never go busy
      pix_busy_reg    <= sel_ok && (avs_writedata_i[FINE_W-1:0] != 5'h00);
      pulses_left_reg <= 7'(FINE_PULSES_PER_STEP) * {2'b00, avs_writedata_i[FINE_W-1:0]};
    end else if (pix_busy_reg && sel_edge) begin
      pulses_left_reg <= pulses_left_reg - 7'h01;
      if (pulses_left_reg == 7'h01) begin
        pix_busy_reg <= 1'b0;
      end
    end
  end

  // System tick divider and second-pulse supervision
  logic [2:0]  tick_div_reg;
  logic        sys_tick;
  logic        pps_prev_reg;
  logic        pps_armed_reg;
  logic [31:0] pps_ticks_reg;
  logic        pps_edge;
  logic        mismatch_event;
  logic [31:0] pps_ticks_now;

  assign sys_tick       = (tick_div_reg == 3'(SYS_TICK_DIV - 1));
  assign pps_edge       = second_pulse_i && !pps_prev_reg;
  // A tick on the closing edge still belongs to the interval that this edge ends
  assign pps_ticks_now  = pps_ticks_reg + {31'h0000_0000, sys_tick};
  assign mismatch_event = pps_edge && pps_armed_reg && (pps_ticks_now != 32'(PPS_TICKS));

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tick_div_reg <= 3'h0;
    end else begin
      tick_div_reg <= sys_tick ? 3'h0 : tick_div_reg + 3'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pps_prev_reg  <= 1'b0;
      pps_armed_reg <= 1'b0;
      pps_ticks_reg <= 32'h0000_0000;
    end else begin
      pps_prev_reg <= second_pulse_i;
      if (pps_edge) begin
        pps_armed_reg <= 1'b1;
        pps_ticks_reg <= 32'h0000_0000;
      end else if (sys_tick && pps_ticks_reg != 32'hffff_ffff) begin
        pps_ticks_reg <= pps_ticks_reg + 32'h0000_0001;
      end
    end
  end

  // A mismatch in a clear cycle loads one instead of zero, so no mismatch is lost
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mismatch_reg <= 8'h00;
    end else if (mismatch_event) begin
      mismatch_reg <= control_reg[CTRL_CLR_MISMATCH_BIT] ? 8'h01 : sat_inc(mismatch_reg);
    end else if (control_reg[CTRL_CLR_MISMATCH_BIT]) begin
      mismatch_reg <= 8'h00;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cal_delay_reg <= 8'h00;
    end else begin
      cal_delay_reg <= second_pulse_cal_i;
    end
  end

  // Rate scaler: accept edges over a one-second gate, saturating at 16 bits
  logic [31:0] gate_cnt_reg;
  logic [15:0] acc_cnt_reg;
  logic        acc_prev_reg;
  logic        gate_end;
  logic        acc_edge;

  assign gate_end = (gate_cnt_reg == 32'(SCALER_CYCLES - 1));
  assign acc_edge = accept_trigger_i && !acc_prev_reg;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gate_cnt_reg <= 32'h0000_0000;
      acc_cnt_reg  <= 16'h0000;
      acc_prev_reg <= 1'b0;
      rate_reg     <= 16'h0000;
    end else begin
      acc_prev_reg <= accept_trigger_i;
      gate_cnt_reg <= gate_end ? 32'h0000_0000 : gate_cnt_reg + 32'h0000_0001;
      if (gate_end) begin
        rate_reg    <= acc_cnt_reg;
        // An edge on the gate end opens the next window, so none is lost
        acc_cnt_reg <= {15'h0000, acc_edge};
      end else if (acc_edge && acc_cnt_reg != 16'hffff) begin
        acc_cnt_reg <= acc_cnt_reg + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer cycle longer than one");
  a_shape_bypass: assert property (win_len == 3'h0 ##1 win_len == 3'h0 |-> shaped_hit_o == $past(masked_hit_reg))
    else $error("hits shaped with zero window");
  a_shape_edge: assert property (win_len != 3'h0 && masked_hit_reg[0] && !masked_prev_reg[0] |=> shaped_hit_o[0])
    else $error("leading edge did not start shaped pulse");
  a_select_reserved: assert property (target_sel_reg[3] == 1'b0 && target_sel_reg[7] == 1'b0)
    else $error("reserved select bits set");
  a_coarse_nobusy: assert property (wr_en && idx == IDX_PIX_DEL && avs_writedata_i[4:0] == 5'h00 |=> !pix_busy_reg)
    else $error("coarse write set busy");
  a_busy_cause: assert property ($rose(pix_busy_reg) |-> $past(wr_en && idx == IDX_PIX_DEL))
    else $error("busy rose without pixel delay write");
  a_busy_absent: assert property (wr_en && idx == IDX_PIX_DEL && !sel_ok |=> !pix_busy_reg)
    else $error("busy set for nonexistent pixel");
  a_busy_restart: assert property (pix_busy_reg && wr_en && idx == IDX_PIX_DEL && sel_ok && avs_writedata_i[4:0] != 5'h00
    |=> pix_busy_reg && pulses_left_reg == 7'(2 * $past(avs_writedata_i[4:0])))
    else $error("busy restart count wrong");
  a_mask_force: assert property (!mask_flat[0] |=> !masked_hit_reg[0])
    else $error("masked pixel not forced low");
  a_mask_exists: assert property (mask_reg[1] == (mask_reg[1] & 8'h3e))
    else $error("mask bit at nonexistent pixel");
  a_count_sat: assert property (mismatch_reg == 8'hff && !control_reg[5] |=> mismatch_reg == 8'hff)
    else $error("mismatch counter wrapped");
  a_count_clear: assert property (control_reg[5] && !mismatch_event |=> mismatch_reg == 8'h00)
    else $error("mismatch counter not cleared");
  a_count_inc: assert property (mismatch_event && !control_reg[5] && mismatch_reg != 8'hff
    |=> mismatch_reg == $past(mismatch_reg) + 8'h01)
    else $error("mismatch not counted");

  c_busy_done:  cover property (pix_busy_reg ##1 !pix_busy_reg);
  c_mismatch:   cover property (mismatch_event);
  c_shaped:     cover property (win_len != 3'h0 && shaped_hit_o[0] && !masked_hit_reg[0]);
  c_rate_latch: cover property (gate_end && acc_cnt_reg != 16'h0000);

endmodule
